// ---- src/sfd_pkg.sv ----
// Package of encodings, timing counts and class codes for the string/flag/system decoder
package sfd_pkg;

	// Prefix bytes
	localparam logic [7:0] REPEAT_WHILE_EQUAL_PREFIX   = 8'h00_F3;
	localparam logic [7:0] REPEAT_WHILE_UNEQUAL_PREFIX = 8'h00_F2;
	localparam logic [7:0] BUS_LOCK_PREFIX             = 8'h00_F0;

	// String opcodes with the width bit masked out (upper seven bits)
	localparam logic [6:0] STRING_COMPARE_OP = 7'h0_53;
	localparam logic [6:0] STRING_LOAD_OP    = 7'h0_56;
	localparam logic [6:0] STRING_MOVE_OP    = 7'h0_52;
	localparam logic [6:0] STRING_SCAN_OP    = 7'h0_57;
	localparam logic [6:0] STRING_STORE_OP   = 7'h0_55;

	// Flag and decimal opcodes; the two ASCII adjust opcodes take ASCII_ADJUST_BASE as a second byte
	localparam logic [7:0] CARRY_CLEAR_OP         = 8'h00_F8;
	localparam logic [7:0] CARRY_SET_OP           = 8'h00_F9;
	localparam logic [7:0] CARRY_COMPLEMENT_OP    = 8'h00_F5;
	localparam logic [7:0] DIRECTION_CLEAR_OP     = 8'h00_FC;
	localparam logic [7:0] DIRECTION_SET_OP       = 8'h00_FD;
	localparam logic [7:0] INT_ENABLE_CLEAR_OP    = 8'h00_FA;
	localparam logic [7:0] INT_ENABLE_SET_OP      = 8'h00_FB;
	localparam logic [7:0] FLAGS_TO_ACC_HIGH_OP   = 8'h00_9F;
	localparam logic [7:0] ACC_HIGH_TO_FLAGS_OP   = 8'h00_9E;
	localparam logic [7:0] DECIMAL_ADJUST_ADD_OP  = 8'h00_27;
	localparam logic [7:0] DECIMAL_ADJUST_SUB_OP  = 8'h00_2F;
	localparam logic [7:0] ASCII_ADJUST_MUL_OP    = 8'h00_D4;
	localparam logic [7:0] ASCII_ADJUST_DIV_OP    = 8'h00_D5;
	localparam logic [7:0] ASCII_ADJUST_BASE      = 8'h00_0A;

	// Two-byte escape and second bytes
	localparam logic [7:0] ESCAPE_BYTE                   = 8'h00_0F;
	localparam logic [7:0] MOVE_TO_CONTROL_OP            = 8'h00_22;
	localparam logic [7:0] TASK_SWITCHED_CLEAR_OP        = 8'h00_06;
	localparam logic [7:0] CACHE_INVALIDATE_OP           = 8'h00_08;
	localparam logic [7:0] CACHE_WRITEBACK_INVALIDATE_OP = 8'h00_09;
	localparam logic [7:0] TRANSLATION_GROUP_OP          = 8'h00_01;
	localparam logic [2:0] TRANSLATION_ENTRY_FIELD       = 3'h7;
	localparam logic [2:0] CONTROL_REGISTER_ZERO_FIELD   = 3'h0;
	localparam int         MODRM_REG_LSB                 = 3;
	localparam int         MODRM_MOD_LSB                 = 6;

	// Clock counts
	localparam logic [7:0] CYC_ZERO_COUNT     = 8'h00_05;
	localparam logic [7:0] CYC_STR_BASE       = 8'h00_07;
	localparam logic [7:0] CYC_CMP_PER        = 8'h00_07;
	localparam logic [7:0] CYC_LOAD_PER       = 8'h00_04;
	localparam logic [7:0] CYC_STORE_PER      = 8'h00_04;
	localparam logic [7:0] CYC_SCAN_PER       = 8'h00_05;
	localparam logic [7:0] CYC_MOVE_ONE       = 8'h00_0D;
	localparam logic [7:0] CYC_MOVE_BASE      = 8'h00_0C;
	localparam logic [7:0] CYC_MOVE_PER       = 8'h00_03;
	localparam logic [7:0] CYC_FLAG           = 8'h00_02;
	localparam logic [7:0] CYC_INT_FLAG       = 8'h00_05;
	localparam logic [7:0] CYC_FLAGS_TO_ACC   = 8'h00_03;
	localparam logic [7:0] CYC_ACC_TO_FLAGS   = 8'h00_02;
	localparam logic [7:0] CYC_ADJ_MUL        = 8'h00_0F;
	localparam logic [7:0] CYC_ADJ_DIV        = 8'h00_0E;
	localparam logic [7:0] CYC_DEC_ADJ        = 8'h00_02;
	localparam logic [7:0] CYC_CTRL_ZERO      = 8'h00_10;
	localparam logic [7:0] CYC_TASK_CLEAR     = 8'h00_07;
	localparam logic [7:0] CYC_MISS_PENALTY   = 8'h00_02;
	localparam logic [7:0] CYC_INVALIDATE     = 8'h00_04;
	localparam logic [7:0] CYC_WB_INVALIDATE  = 8'h00_05;
	localparam logic [7:0] CYC_TLB_HIT        = 8'h00_0C;
	localparam logic [7:0] CYC_TLB_MISS       = 8'h00_0B;
	localparam logic [7:0] CYC_LOCK           = 8'h00_01;

	// Operation class reported to the pipeline
	typedef enum logic [4:0] {
		SFD_OP_NONE       = 5'h00,
		SFD_OP_STR_CMP    = 5'h01,
		SFD_OP_STR_LOAD   = 5'h02,
		SFD_OP_STR_MOVE   = 5'h03,
		SFD_OP_STR_SCAN   = 5'h04,
		SFD_OP_STR_STORE  = 5'h05,
		SFD_OP_CARRY_CLR  = 5'h06,
		SFD_OP_CARRY_SET  = 5'h07,
		SFD_OP_CARRY_CMP  = 5'h08,
		SFD_OP_DIR_CLR    = 5'h09,
		SFD_OP_DIR_SET    = 5'h0A,
		SFD_OP_INT_CLR    = 5'h0B,
		SFD_OP_INT_SET    = 5'h0C,
		SFD_OP_FLAGS_ACC  = 5'h0D,
		SFD_OP_ACC_FLAGS  = 5'h0E,
		SFD_OP_ADJ_MUL    = 5'h0F,
		SFD_OP_ADJ_DIV    = 5'h10,
		SFD_OP_DEC_ADD    = 5'h11,
		SFD_OP_DEC_SUB    = 5'h12,
		SFD_OP_CTRL_ZERO  = 5'h13,
		SFD_OP_TASK_CLR   = 5'h14,
		SFD_OP_CACHE_INV  = 5'h15,
		SFD_OP_CACHE_WBI  = 5'h16,
		SFD_OP_TLB_INV    = 5'h17,
		SFD_OP_UNKNOWN    = 5'h1F
	} sfd_op_t;

	// Repeat condition kinds
	typedef enum logic [1:0] {
		SFD_REP_NONE    = 2'h0,
		SFD_REP_EQUAL   = 2'h1,
		SFD_REP_UNEQUAL = 2'h3
	} sfd_rep_t;

endpackage

// ---- src/sfd_string_seq.sv ----
// Iteration sequencer for count-repeated string operations
`timescale 1ns/10ps
module sfd_string_seq
	import sfd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clkEn,
	input  wire logic        start,
	input  wire logic [31:0] startCount,
	input  wire sfd_rep_t    repKind,
	input  wire logic        condOp,
	input  wire logic        iterDone,
	input  wire logic        iterEqual,
	output logic             iterActive_r,
	output logic [31:0]      count_r,
	output logic             finish_r
);

	// Counting state; one iteration handed to the pipeline at a time
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			iterActive_r <= 1'b0;
			count_r      <= '0;
			finish_r     <= 1'b0;
		end else if (clkEn) begin
			finish_r <= 1'b0;
			if (start && !iterActive_r) begin
				count_r <= startCount;
				// Zero count runs no iteration and touches no memory
				iterActive_r <= (startCount != '0);
				finish_r     <= (startCount == '0);
			end else if (iterActive_r && iterDone) begin
				count_r <= count_r - 32'h0000_0001;
				// Compare and scan stop early once the prefix condition fails
				if (count_r == 32'h0000_0001 ||
					(condOp && repKind == SFD_REP_EQUAL && !iterEqual) ||
					(condOp && repKind == SFD_REP_UNEQUAL && iterEqual)) begin
					iterActive_r <= 1'b0;
					finish_r     <= 1'b1;
				end
			end
		end
	end

endmodule

// ---- src/sfd_decoder.sv ----
// Decoder and clock-count generator for string, flag, decimal and system operations
`timescale 1ns/10ps
module sfd_decoder
	import sfd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clkEn,
	input  wire logic        byteValid,
	input  wire logic [7:0]  instrByte,
	input  wire logic        addrSize32,
	input  wire logic [31:0] countRegister32,
	input  wire logic        cacheMiss,
	input  wire logic        tlbEntryPresent,
	input  wire logic        iterDone,
	input  wire logic        iterEqual,
	output logic             byteReady_r,
	output logic             decodeValid_r,
	output sfd_op_t          opClass_r,
	output logic             opWide_r,
	output logic [15:0]      opCycles_r,
	output logic             lockRequest_r,
	output sfd_rep_t         repKind_r,
	output logic             iterRequest_r,
	output logic [31:0]      countOut_r,
	output logic             countWrite_r,
	output logic             stringDone_r
);

	// Decode walk; Gray codes along prefix, opcode, operand path
	typedef enum logic [2:0] {
		SFD_ST_FIRST  = 3'b000,
		SFD_ST_ESCAPE = 3'b001,
		SFD_ST_MODRM  = 3'b011,
		SFD_ST_ADJUST = 3'b010,
		SFD_ST_STRING = 3'b110
	} sfd_state_t;

	sfd_state_t  state_r;
	sfd_rep_t    pendRep_r;
	logic        pendLock_r;
	logic [7:0]  heldByte_r;
	logic        strCond_r;
	logic        seqStart;
	logic        seqActive;
	logic [31:0] seqCount;
	logic        seqFinish;
	logic [31:0] startCount;

	// Base plus per-iteration product, used by repeated forms except zero counts and a one-element move
	function automatic logic [15:0] iterCost(input logic [7:0] base, input logic [7:0] per,
		input logic [31:0] cnt);
		logic [39:0] prod;
		prod = {32'h0000_0000, per} * {8'h00, cnt};
		iterCost = (prod > 40'h00_0000_FFFF) ? 16'hFFFF :
			16'(prod[15:0] + {8'h00, base});
	endfunction

	// Zero-count check shared by all repeated forms
	function automatic logic isZero(input logic [31:0] cnt);
		isZero = (cnt == 32'h0000_0000);
	endfunction

	// Count register width follows address size
	assign startCount = addrSize32 ? countRegister32 : {16'h0000, countRegister32[15:0]};
	assign seqStart   = byteValid && byteReady_r && state_r == SFD_ST_FIRST &&
		pendRep_r != SFD_REP_NONE && instrByte[7:5] == 3'b101 &&
		(instrByte[7:1] == STRING_COMPARE_OP || instrByte[7:1] == STRING_LOAD_OP ||
		 instrByte[7:1] == STRING_MOVE_OP || instrByte[7:1] == STRING_SCAN_OP ||
		 instrByte[7:1] == STRING_STORE_OP);

	sfd_string_seq sfd_string_seq_inst (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.clkEn        (clkEn),
		.start        (seqStart),
		.startCount   (startCount),
		.repKind      (repKind_r),
		.condOp       (strCond_r),
		.iterDone     (iterDone),
		.iterEqual    (iterEqual),
		.iterActive_r (seqActive),
		.count_r      (seqCount),
		.finish_r     (seqFinish)
	);

	// Condition latched at start; the opcode byte is gone afterwards
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			strCond_r <= 1'b0;
		end else if (clkEn && seqStart) begin
			strCond_r <= instrByte[7:1] == STRING_COMPARE_OP || instrByte[7:1] == STRING_SCAN_OP;
		end
	end

	// Fetch is stalled while a repeated string runs, so no byte is lost
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			byteReady_r <= 1'b0;
		end else if (clkEn) begin
			byteReady_r <= !(seqStart || (seqActive && !seqFinish));
		end
	end

	// Iteration handshake and count write-back toward the register file
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			iterRequest_r <= 1'b0;
			countOut_r    <= '0;
			countWrite_r  <= 1'b0;
			stringDone_r  <= 1'b0;
		end else if (clkEn) begin
			iterRequest_r <= seqActive && !(iterDone && seqCount == 32'h0000_0001);
			countOut_r    <= seqCount - 32'(iterDone);
			countWrite_r  <= seqActive && iterDone;
			stringDone_r  <= seqFinish;
		end
	end

	// Main decode: prefixes, opcodes and their clock counts
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_r       <= SFD_ST_FIRST;
			pendRep_r     <= SFD_REP_NONE;
			pendLock_r    <= 1'b0;
			heldByte_r    <= '0;
			decodeValid_r <= 1'b0;
			opClass_r     <= SFD_OP_NONE;
			opWide_r      <= 1'b0;
			opCycles_r    <= '0;
			lockRequest_r <= 1'b0;
			repKind_r     <= SFD_REP_NONE;
		end else if (clkEn) begin
			decodeValid_r <= 1'b0;
			if (byteValid && byteReady_r) begin
				unique case (state_r)
					SFD_ST_FIRST: begin
						if (instrByte == REPEAT_WHILE_EQUAL_PREFIX) begin
							pendRep_r <= SFD_REP_EQUAL;
						end else if (instrByte == REPEAT_WHILE_UNEQUAL_PREFIX) begin
							pendRep_r <= SFD_REP_UNEQUAL;
						end else if (instrByte == BUS_LOCK_PREFIX) begin
							// Prefix reported as its own 1-clock item
							pendLock_r    <= 1'b1;
							decodeValid_r <= 1'b1;
							opClass_r     <= SFD_OP_NONE;
							opCycles_r    <= {8'h00, CYC_LOCK};
							lockRequest_r <= 1'b1;
						end else if (instrByte == ESCAPE_BYTE) begin
							state_r <= SFD_ST_ESCAPE;
						end else if (instrByte == ASCII_ADJUST_MUL_OP ||
							instrByte == ASCII_ADJUST_DIV_OP) begin
							heldByte_r <= instrByte;
							state_r    <= SFD_ST_ADJUST;
						end else begin
							decodeValid_r <= 1'b1;
							opWide_r      <= instrByte[0];
							lockRequest_r <= pendLock_r;
							repKind_r     <= pendRep_r;
							pendRep_r     <= SFD_REP_NONE;
							pendLock_r    <= 1'b0;
							opCycles_r    <= {8'h00, CYC_FLAG};
							opClass_r     <= SFD_OP_UNKNOWN;
							if (seqStart) begin
								// Unrepeated string forms are left to another decoder
								if (isZero(startCount)) begin
									opCycles_r <= {8'h00, CYC_ZERO_COUNT};
								end else if (instrByte[7:1] == STRING_COMPARE_OP) begin
									opClass_r  <= SFD_OP_STR_CMP;
									opCycles_r <= iterCost(CYC_STR_BASE, CYC_CMP_PER, startCount);
								end else if (instrByte[7:1] == STRING_LOAD_OP) begin
									opCycles_r <= iterCost(CYC_STR_BASE, CYC_LOAD_PER, startCount);
								end else if (instrByte[7:1] == STRING_MOVE_OP) begin
									opCycles_r <= (startCount == 32'h0000_0001) ? {8'h00, CYC_MOVE_ONE} :
										iterCost(CYC_MOVE_BASE, CYC_MOVE_PER, startCount);
								end else if (instrByte[7:1] == STRING_SCAN_OP) begin
									opCycles_r <= iterCost(CYC_STR_BASE, CYC_SCAN_PER, startCount);
								end else begin
									opCycles_r <= iterCost(CYC_STR_BASE, CYC_STORE_PER, startCount);
								end
								unique case (instrByte[7:1])
									STRING_COMPARE_OP: opClass_r <= SFD_OP_STR_CMP;
									STRING_LOAD_OP:    opClass_r <= SFD_OP_STR_LOAD;
									STRING_MOVE_OP:    opClass_r <= SFD_OP_STR_MOVE;
									STRING_SCAN_OP:    opClass_r <= SFD_OP_STR_SCAN;
									default:           opClass_r <= SFD_OP_STR_STORE;
								endcase
							end else begin
								unique case (instrByte)
									CARRY_CLEAR_OP:      opClass_r <= SFD_OP_CARRY_CLR;
									CARRY_SET_OP:        opClass_r <= SFD_OP_CARRY_SET;
									CARRY_COMPLEMENT_OP: opClass_r <= SFD_OP_CARRY_CMP;
									DIRECTION_CLEAR_OP:  opClass_r <= SFD_OP_DIR_CLR;
									DIRECTION_SET_OP:    opClass_r <= SFD_OP_DIR_SET;
									INT_ENABLE_CLEAR_OP: begin
										opClass_r  <= SFD_OP_INT_CLR;
										opCycles_r <= {8'h00, CYC_INT_FLAG};
									end
									INT_ENABLE_SET_OP: begin
										opClass_r  <= SFD_OP_INT_SET;
										opCycles_r <= {8'h00, CYC_INT_FLAG};
									end
									FLAGS_TO_ACC_HIGH_OP: begin
										opClass_r  <= SFD_OP_FLAGS_ACC;
										opCycles_r <= {8'h00, CYC_FLAGS_TO_ACC};
									end
									ACC_HIGH_TO_FLAGS_OP: begin
										opClass_r  <= SFD_OP_ACC_FLAGS;
										opCycles_r <= {8'h00, CYC_ACC_TO_FLAGS};
									end
									DECIMAL_ADJUST_ADD_OP: begin
										opClass_r  <= SFD_OP_DEC_ADD;
										opCycles_r <= {8'h00, CYC_DEC_ADJ};
									end
									DECIMAL_ADJUST_SUB_OP: begin
										opClass_r  <= SFD_OP_DEC_SUB;
										opCycles_r <= {8'h00, CYC_DEC_ADJ};
									end
									default: opCycles_r <= '0;
								endcase
							end
						end
					end
					SFD_ST_ADJUST: begin
						// Only base ten second byte is recognised
						state_r       <= SFD_ST_FIRST;
						decodeValid_r <= 1'b1;
						lockRequest_r <= pendLock_r;
						repKind_r     <= pendRep_r;
						pendRep_r     <= SFD_REP_NONE;
						pendLock_r    <= 1'b0;
						if (instrByte != ASCII_ADJUST_BASE) begin
							opClass_r  <= SFD_OP_UNKNOWN;
							opCycles_r <= '0;
						end else if (heldByte_r == ASCII_ADJUST_MUL_OP) begin
							opClass_r  <= SFD_OP_ADJ_MUL;
							opCycles_r <= {8'h00, CYC_ADJ_MUL};
						end else begin
							opClass_r  <= SFD_OP_ADJ_DIV;
							opCycles_r <= {8'h00, CYC_ADJ_DIV};
						end
					end
					SFD_ST_ESCAPE: begin
						heldByte_r <= instrByte;
						if (instrByte == MOVE_TO_CONTROL_OP || instrByte == TRANSLATION_GROUP_OP) begin
							state_r <= SFD_ST_MODRM;
						end else begin
							state_r       <= SFD_ST_FIRST;
							decodeValid_r <= 1'b1;
							lockRequest_r <= pendLock_r;
							repKind_r     <= pendRep_r;
							pendRep_r     <= SFD_REP_NONE;
							pendLock_r    <= 1'b0;
							unique case (instrByte)
								TASK_SWITCHED_CLEAR_OP: begin
									opClass_r  <= SFD_OP_TASK_CLR;
									opCycles_r <= {8'h00, CYC_TASK_CLEAR} +
										(cacheMiss ? {8'h00, CYC_MISS_PENALTY} : 16'h0000);
								end
								CACHE_INVALIDATE_OP: begin
									opClass_r  <= SFD_OP_CACHE_INV;
									opCycles_r <= {8'h00, CYC_INVALIDATE};
								end
								CACHE_WRITEBACK_INVALIDATE_OP: begin
									opClass_r  <= SFD_OP_CACHE_WBI;
									opCycles_r <= {8'h00, CYC_WB_INVALIDATE};
								end
								default: begin
									opClass_r  <= SFD_OP_UNKNOWN;
									opCycles_r <= '0;
								end
							endcase
						end
					end
					SFD_ST_MODRM: begin
						state_r       <= SFD_ST_FIRST;
						decodeValid_r <= 1'b1;
						lockRequest_r <= pendLock_r;
						repKind_r     <= pendRep_r;
						pendRep_r     <= SFD_REP_NONE;
						pendLock_r    <= 1'b0;
						opClass_r     <= SFD_OP_UNKNOWN;
						opCycles_r    <= '0;
						if (heldByte_r == MOVE_TO_CONTROL_OP &&
							instrByte[MODRM_MOD_LSB +: 2] == 2'b11 &&
							instrByte[MODRM_REG_LSB +: 3] == CONTROL_REGISTER_ZERO_FIELD) begin
							opClass_r  <= SFD_OP_CTRL_ZERO;
							opCycles_r <= {8'h00, CYC_CTRL_ZERO} +
								(cacheMiss ? {8'h00, CYC_MISS_PENALTY} : 16'h0000);
						end else if (heldByte_r == TRANSLATION_GROUP_OP &&
							instrByte[MODRM_MOD_LSB +: 2] != 2'b11 &&
							instrByte[MODRM_REG_LSB +: 3] == TRANSLATION_ENTRY_FIELD) begin
							opClass_r  <= SFD_OP_TLB_INV;
							opCycles_r <= {8'h00, tlbEntryPresent ? CYC_TLB_HIT : CYC_TLB_MISS};
						end
					end
					default: state_r <= SFD_ST_FIRST;
				endcase
			end
		end
	end

endmodule

// ---- verif/sfd_decoder_monitor.sv ----
// Concurrent checks on the decoder ports
`timescale 1ns/10ps
module sfd_decoder_monitor
	import sfd_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        clkEn,
	input wire logic        byteValid,
	input wire logic [7:0]  instrByte,
	input wire logic        cacheMiss,
	input wire logic        tlbEntryPresent,
	input wire logic        iterDone,
	input wire logic        byteReady_r,
	input wire logic        decodeValid_r,
	input wire sfd_op_t     opClass_r,
	input wire logic [15:0] opCycles_r,
	input wire logic        lockRequest_r,
	input wire sfd_rep_t    repKind_r,
	input wire logic        iterRequest_r,
	input wire logic        countWrite_r,
	input wire logic        stringDone_r
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Fixed counts per decoded class
	property p_two_clk;
		decodeValid_r && opClass_r inside {[SFD_OP_CARRY_CLR:SFD_OP_DIR_SET], SFD_OP_ACC_FLAGS,
			SFD_OP_DEC_ADD, SFD_OP_DEC_SUB} |-> opCycles_r == 16'h0002;
	endproperty
	a_two_clk: assert property (p_two_clk) else $error("two-clock op count wrong");
	property p_int_en;
		decodeValid_r && opClass_r inside {SFD_OP_INT_CLR, SFD_OP_INT_SET} |-> opCycles_r == 16'h0005;
	endproperty
	a_int_en: assert property (p_int_en) else $error("interrupt flag count wrong");
	property p_adjust;
		decodeValid_r && opClass_r inside {SFD_OP_ADJ_MUL, SFD_OP_ADJ_DIV, SFD_OP_FLAGS_ACC} |->
			opCycles_r == (opClass_r == SFD_OP_ADJ_MUL ? 16'h000F :
			opClass_r == SFD_OP_ADJ_DIV ? 16'h000E : 16'h0003);
	endproperty
	a_adjust: assert property (p_adjust) else $error("adjust count wrong");
	// Miss penalty follows the level seen with the final byte
	property p_miss;
		decodeValid_r && opClass_r inside {SFD_OP_CTRL_ZERO, SFD_OP_TASK_CLR} |->
			opCycles_r == (opClass_r == SFD_OP_CTRL_ZERO ? 16'h0010 : 16'h0007)
			+ ($past(cacheMiss) ? 16'h0002 : 16'h0000);
	endproperty
	a_miss: assert property (p_miss) else $error("control op count wrong");
	property p_cache;
		decodeValid_r && opClass_r inside {SFD_OP_CACHE_INV, SFD_OP_CACHE_WBI} |->
			opCycles_r == (opClass_r == SFD_OP_CACHE_INV ? 16'h0004 : 16'h0005);
	endproperty
	a_cache: assert property (p_cache) else $error("cache op count wrong");
	property p_tlb;
		decodeValid_r && opClass_r == SFD_OP_TLB_INV |->
			opCycles_r == ($past(tlbEntryPresent) ? 16'h000C : 16'h000B);
	endproperty
	a_tlb: assert property (p_tlb) else $error("entry invalidate count wrong");
	property p_lock;
		clkEn && byteValid && byteReady_r && instrByte == BUS_LOCK_PREFIX |=> decodeValid_r
			&& lockRequest_r && opCycles_r == 16'h0001 && opClass_r == SFD_OP_NONE;
	endproperty
	a_lock: assert property (p_lock) else $error("lock prefix not reported");
	// Each accepted iteration answers with one count update
	property p_iter;
		clkEn && iterDone && iterRequest_r |=> countWrite_r;
	endproperty
	a_iter: assert property (p_iter) else $error("no count update after iteration");
	property p_zero;
		decodeValid_r && opClass_r inside {[SFD_OP_STR_CMP:SFD_OP_STR_STORE]}
			&& repKind_r != SFD_REP_NONE && opCycles_r == 16'h0005 |=> stringDone_r && !countWrite_r;
	endproperty
	a_zero: assert property (p_zero) else $error("zero count not finished at once");
	property p_done;
		stringDone_r |=> !stringDone_r ##[0:1] byteReady_r;
	endproperty
	a_done: assert property (p_done) else $error("fetch not resumed after string");
endmodule
bind sfd_decoder sfd_decoder_monitor sfd_decoder_monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n),
	.clkEn(clkEn), .byteValid(byteValid), .instrByte(instrByte), .cacheMiss(cacheMiss),
	.tlbEntryPresent(tlbEntryPresent), .iterDone(iterDone), .byteReady_r(byteReady_r),
	.decodeValid_r(decodeValid_r), .opClass_r(opClass_r), .opCycles_r(opCycles_r),
	.lockRequest_r(lockRequest_r), .repKind_r(repKind_r), .iterRequest_r(iterRequest_r),
	.countWrite_r(countWrite_r), .stringDone_r(stringDone_r));

// ---- verif/sfd_pipe_model.sv ----
// Execution pipeline model answering string iteration requests
`timescale 1ns/10ps
module sfd_pipe_model (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       iterRequest_r,
	input  wire logic       eqNorm,
	input  wire logic [7:0] failAt,
	input  wire logic       slow,
	output logic            iterDone,
	output logic            iterEqual
);
	int n;
	int gap;

	// Gap of three keeps the next pulse clear of the finish of the last one
	initial begin
		iterDone = 0;
		iterEqual = 0;
		n = 0;
		gap = 1;
		forever begin
			@(posedge clk_sys);
			#1;
			if (reset_n && iterRequest_r && gap == 0) begin
				n++;
				iterDone = 1;
				iterEqual = (n == failAt) ? ~eqNorm : eqNorm;
				gap = slow ? 3 + $urandom % 4 : 3;
			end else begin
				iterDone = 0;
				iterEqual = ~iterEqual; // Unqualified: never hold the last result
				if (!reset_n || !iterRequest_r) begin
					n = 0;
					gap = 1;
				end else
					gap--;
			end
		end
	end
endmodule

// ---- verif/sfd_decoder_tb.sv ----
// Self-checking bench for the string, flag and system decoder
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module sfd_decoder_tb;
	import sfd_pkg::*;
	typedef struct packed {sfd_op_t op; logic [15:0] cyc; logic lock; sfd_rep_t repeat_prefix;} sfd_exp_t;
	logic        clk_sys, reset_n, clkEn, byteValid, addrSize32, cacheMiss, tlbEntryPresent;
	logic        iterDone, iterEqual, byteReady_r, decodeValid_r, lockRequest_r, opWide_r;
	logic        iterRequest_r, countWrite_r, stringDone_r, eqNorm, slow;
	logic [7:0]  instrByte, failAt;
	logic [15:0] opCycles_r;
	logic [31:0] countRegister32, countOut_r;
	sfd_op_t     opClass_r;
	sfd_rep_t    repKind_r;
	int          num_errors = 0, total_checks = 0, cycles = 0, doneCnt = 0;
	sfd_exp_t    expQ[$], e;
	logic [15:0] cntQ[$];
	logic [7:0]  fB[11] = '{CARRY_CLEAR_OP, CARRY_SET_OP, CARRY_COMPLEMENT_OP, DIRECTION_CLEAR_OP,
		DIRECTION_SET_OP, INT_ENABLE_CLEAR_OP, INT_ENABLE_SET_OP, FLAGS_TO_ACC_HIGH_OP,
		ACC_HIGH_TO_FLAGS_OP, DECIMAL_ADJUST_ADD_OP, DECIMAL_ADJUST_SUB_OP};
	sfd_op_t     fOp[11] = '{SFD_OP_CARRY_CLR, SFD_OP_CARRY_SET, SFD_OP_CARRY_CMP, SFD_OP_DIR_CLR,
		SFD_OP_DIR_SET, SFD_OP_INT_CLR, SFD_OP_INT_SET, SFD_OP_FLAGS_ACC, SFD_OP_ACC_FLAGS,
		SFD_OP_DEC_ADD, SFD_OP_DEC_SUB};
	logic [7:0]  fC[11] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h05, 8'h05, 8'h03, 8'h02, 8'h02, 8'h02};
	sfd_op_t     sOp[5] = '{SFD_OP_STR_CMP, SFD_OP_STR_LOAD, SFD_OP_STR_MOVE, SFD_OP_STR_SCAN,
		SFD_OP_STR_STORE};
	logic [6:0]  sCode[5] = '{STRING_COMPARE_OP, STRING_LOAD_OP, STRING_MOVE_OP, STRING_SCAN_OP,
		STRING_STORE_OP};

	sfd_decoder sfd_decoder_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
		.byteValid(byteValid), .instrByte(instrByte), .addrSize32(addrSize32),
		.countRegister32(countRegister32), .cacheMiss(cacheMiss), .tlbEntryPresent(tlbEntryPresent),
		.iterDone(iterDone), .iterEqual(iterEqual), .byteReady_r(byteReady_r),
		.decodeValid_r(decodeValid_r), .opClass_r(opClass_r), .opWide_r(opWide_r),
		.opCycles_r(opCycles_r),
		.lockRequest_r(lockRequest_r), .repKind_r(repKind_r), .iterRequest_r(iterRequest_r),
		.countOut_r(countOut_r), .countWrite_r(countWrite_r), .stringDone_r(stringDone_r));
	sfd_pipe_model sfd_pipe_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.iterRequest_r(iterRequest_r), .eqNorm(eqNorm), .failAt(failAt), .slow(slow),
		.iterDone(iterDone), .iterEqual(iterEqual));

	// 200 MHz clock
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hold the byte until an edge with ready high takes it
	task sendByte(input logic [7:0] b);
		int n;
		byteValid = 1;
		instrByte = b;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!byteReady_r && n < 100);
		#1;
	endtask

	task note(input sfd_op_t op, input logic [15:0] cyc, input logic lock = 0,
		input sfd_rep_t repeat_prefix = SFD_REP_NONE);
		expQ.push_back('{op, cyc, lock, repeat_prefix});
	endtask

	task seq(input logic [7:0] a, input logic [7:0] b, input sfd_op_t op, input logic [15:0] cyc);
		sendByte(a);
		sendByte(b);
		note(op, cyc);
	endtask

	// Ready goes low on the edge that takes a repeated string opcode; idle two edges, then wait
	task waitReady;
		int n;
		byteValid = 0;
		n = 0;
		repeat (2) @(posedge clk_sys);
		while (!byteReady_r && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		#1;
	endtask

	// Result watcher: oldest note against each reported result
	always @(posedge clk_sys) begin
		if (reset_n && decodeValid_r) begin
			if (expQ.size() == 0) `CHK(decodeValid_r, 1'b0)
			else begin
				e = expQ.pop_front();
				`CHK(opClass_r, e.op)
				`CHK(opCycles_r, e.cyc)
				`CHK(lockRequest_r, e.lock)
				`CHK(repKind_r, e.repeat_prefix)
			end
		end
		if (reset_n && countWrite_r) begin
			if (cntQ.size() == 0) `CHK(countWrite_r, 1'b0)
			else `CHK(countOut_r[15:0], cntQ.pop_front())
		end
		if (reset_n && stringDone_r)
			doneCnt++;
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			$display("ERROR %0t: timeout", $time);
			stop_test();
		end
	end

	initial begin
		int i, k, c, n;
		logic [7:0]  pre;
		logic [15:0] cyc, pen;
		reset_n = 0;
		clkEn = 1;
		byteValid = 0;
		instrByte = 8'h00;
		addrSize32 = 0;
		countRegister32 = 32'h0000_0000;
		cacheMiss = 0;
		tlbEntryPresent = 0;
		eqNorm = 0;
		slow = 0;
		failAt = 8'h00;
		k = $urandom(40);
		repeat (8) @(posedge clk_sys);
		#1 reset_n = 1;
		for (i = 0; i < 11; i++) begin
			sendByte(fB[i]);
			note(fOp[i], {8'h00, fC[i]});
		end
		$display("flag and decimal test done");
		sendByte(BUS_LOCK_PREFIX);
		note(SFD_OP_NONE, 16'h0001, 1);
		sendByte(CARRY_SET_OP);
		note(SFD_OP_CARRY_SET, 16'h0002, 1);
		sendByte(CARRY_SET_OP);
		note(SFD_OP_CARRY_SET, 16'h0002);
		$display("lock test done");
		for (i = 0; i < 6; i++) begin
			cacheMiss = 1'($urandom);
			tlbEntryPresent = 1'($urandom);
			pen = cacheMiss ? 16'h0002 : 16'h0000;
			seq(ASCII_ADJUST_MUL_OP, ASCII_ADJUST_BASE, SFD_OP_ADJ_MUL, 16'h000F);
			seq(ASCII_ADJUST_DIV_OP, ASCII_ADJUST_BASE, SFD_OP_ADJ_DIV, 16'h000E);
			seq(ESCAPE_BYTE, TASK_SWITCHED_CLEAR_OP, SFD_OP_TASK_CLR, 16'h0007 + pen);
			seq(ESCAPE_BYTE, CACHE_INVALIDATE_OP, SFD_OP_CACHE_INV, 16'h0004);
			seq(ESCAPE_BYTE, CACHE_WRITEBACK_INVALIDATE_OP, SFD_OP_CACHE_WBI, 16'h0005);
			sendByte(ESCAPE_BYTE);
			seq(MOVE_TO_CONTROL_OP, 8'hC0 | 8'($urandom % 8), SFD_OP_CTRL_ZERO, 16'h0010 + pen);
			sendByte(ESCAPE_BYTE);
			seq(TRANSLATION_GROUP_OP, 8'h38 | 8'(($urandom % 3) << 6) | 8'($urandom % 8),
				SFD_OP_TLB_INV, tlbEntryPresent ? 16'h000C : 16'h000B);
		end
		$display("two-byte test done");
		for (i = 0; i < 40; i++) begin
			k = i % 5;
			c = (i < 15) ? i % 3 : $urandom % 7;
			pre = ((k == 0 || k == 3) && $urandom % 2) ? REPEAT_WHILE_EQUAL_PREFIX :
				REPEAT_WHILE_UNEQUAL_PREFIX;
			eqNorm = (pre == REPEAT_WHILE_EQUAL_PREFIX);
			failAt = (k == 0 || k == 3) ? 8'($urandom % (c + 2)) : 8'h00;
			slow = 1'($urandom);
			addrSize32 = 1'($urandom);
			countRegister32 = {addrSize32 ? 16'h0000 : 16'($urandom), 16'(c)};
			n = (failAt > 0 && failAt <= c) ? failAt : c;
			case (k)
				0: cyc = c ? 16'(7 + 7 * c) : 16'h0005;
				2: cyc = (c > 1) ? 16'(12 + 3 * c) : (c ? 16'h000D : 16'h0005);
				3: cyc = c ? 16'(7 + 5 * c) : 16'h0005;
				default: cyc = c ? 16'(7 + 4 * c) : 16'h0005;
			endcase
			sendByte(pre);
			sendByte({sCode[k], slow});
			`CHK(opWide_r, slow)
			note(sOp[k], cyc, 0, eqNorm ? SFD_REP_EQUAL : SFD_REP_UNEQUAL);
			for (int j = 1; j <= n; j++)
				cntQ.push_back(16'(c - j));
			waitReady();
			`CHK(cntQ.size(), 0)
		end
		`CHK(doneCnt, 40)
		$display("repeated string test done");
		stop_test();
	end
endmodule
